// ---- prog_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module prog_array_model (
  input wire logic clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic req_i, // array request
  input wire tbl_access_pkg::mem_cmd_t cmd_i, // array command
  input wire logic slow_i, // add three wait cycles
  output logic ack_o, // access done, one cycle
  output logic [23:0] rdata_o // program word
);
  import tbl_access_pkg::*;
  logic [23:0] mem_r [logic [22:0]]; // sparse store keyed by space and word
  logic [1:0] wait_r; // wait cycles spent so far
  // answer once per request, data scrambled outside answers
  always @(posedge clk_i or negedge resetn_i) begin : acc
    logic [22:0] k;
    logic [23:0] w;
    k = {cmd_i.cfg, cmd_i.addr};
    w = mem_r.exists(k) ? mem_r[k] : ~{1'b0, k};
    if (!resetn_i) begin
      ack_o <= 1'b0;
      wait_r <= 2'h0;
      rdata_o <= 24'h5a5a5a;
    end else if (req_i && !ack_o && wait_r == (slow_i ? 2'h3 : 2'h0)) begin
      ack_o <= 1'b1;
      wait_r <= 2'h0;
      rdata_o <= w;
      // lane enables pick which bytes land
      if (cmd_i.we) begin
        if (cmd_i.wmask[0]) w[7:0] = cmd_i.wdata[7:0];
        if (cmd_i.wmask[1]) w[15:8] = cmd_i.wdata[15:8];
        if (cmd_i.wmask[2]) w[23:16] = cmd_i.wdata[23:16];
        mem_r[k] = w;
      end
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule : prog_array_model
`default_nettype wire

// ---- program_space_table_access.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbl_access_map.svh"

module program_space_table_access (
  input wire logic core_clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic req_valid_i, // core issues a table op
  input wire tbl_access_pkg::tbl_req_t req_i, // table request
  output logic req_ready_o, // unit idle, request taken
  output logic resp_valid_o, // op finished, one cycle
  output logic [`TBL_DATA_W-1:0] rdata_o, // read result
  input wire logic page_we_i, // write table page register
  input wire logic [`TBL_PAGE_W-1:0] page_wdata_i, // new page
  output logic [`TBL_PAGE_W-1:0] page_o, // table page register
  input wire logic pc_load_i, // load program counter
  input wire logic [`TBL_PC_W-1:0] pc_load_val_i, // load value
  input wire logic pc_step_i, // advance to next word
  output logic [`TBL_PC_W-1:0] pc_o, // program counter
  output logic mem_req_o, // array access request
  output tbl_access_pkg::mem_cmd_t mem_cmd_o, // array command
  input wire logic mem_ack_i, // array access done
  input wire logic [`TBL_PWORD_W-1:0] mem_rdata_i // array data
);
  import tbl_access_pkg::*;

  // access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACCESS = 3'b010,
    ST_DONE = 3'b100
  } tbl_state_t;

  tbl_state_t state_r; // current state
  tbl_state_t state_nxt; // next state
  tbl_req_t req_r; // captured request
  mem_cmd_t cmd_r; // captured array command
  logic [`TBL_PAGE_W-1:0] page_r; // table page register
  logic [`TBL_PAGE_W-1:0] page_nxt; // page next value
  logic [`TBL_DATA_W-1:0] rdata_r; // read result register
  logic [`TBL_PC_W-1:0] pc_r; // program counter
  logic [`TBL_PC_W-1:0] pc_nxt; // counter next value

  // handshake decode
  wire accept = req_valid_i && (state_r == ST_IDLE);
  wire acked = mem_ack_i && (state_r == ST_ACCESS);
  wire is_write = req_i.op[1]; // write forms
  wire is_read_r = !req_r.op[1]; // captured op reads

  // byte select only counts in byte mode
  wire bsel_in = req_i.byte_mode & req_i.ea[0];
  wire bsel_r = req_r.byte_mode & req_r.ea[0];

  // word address: page low bits above ea bits 15..1
  // both halves share this index, so one row serves both
  wire [`TBL_WADDR_W-1:0] waddr =
    {page_r[`TBL_PAGE_MSB:0], req_i.ea[`TBL_EA_W-1:1]};
  // space select from the page top bit
  wire cfg_sel = page_r[`TBL_CFG_BIT];

  // lane data and enables for writes
  wire [`TBL_PWORD_W-1:0] wr_pdata; // write data on lanes
  wire [2:0] wr_mask; // write lane enables

  tbl_write_lane u_wlane (
    .op_i(req_i.op),
    .byte_mode_i(req_i.byte_mode),
    .bsel_i(bsel_in),
    .wdata_i(req_i.wdata),
    .pdata_o(wr_pdata),
    .mask_o(wr_mask)
  );

  // read data formatting from the array word
  wire [`TBL_DATA_W-1:0] rd_fmt; // formatted read word

  tbl_read_format u_rfmt (
    .op_i(req_r.op),
    .byte_mode_i(req_r.byte_mode),
    .bsel_i(bsel_r),
    .pword_i(mem_rdata_i),
    .data_o(rd_fmt)
  );

  // reads never enable lanes
  wire [2:0] cmd_mask = is_write ? wr_mask : `TBL_MASK_NONE;
  // next command built at acceptance, one driver for the whole word
  mem_cmd_t cmd_new; // command for a new request
  assign cmd_new = '{
    we: is_write,
    cfg: cfg_sel,
    addr: waddr,
    wdata: wr_pdata,
    wmask: cmd_mask
  };

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // wait for a request
        if (req_valid_i) begin
          state_nxt = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        // hold until the array answers
        if (mem_ack_i) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // answer for one cycle
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // page register: written by the core any time;
  // a request uses the value standing when accepted
  assign page_nxt = page_we_i ? page_wdata_i : page_r;

  // counter steps by two: word address is half the data address
  assign pc_nxt = pc_load_i ? pc_load_val_i :
    (pc_step_i ? pc_r + `TBL_PC_STEP : pc_r);

  // state and control registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      page_r <= `TBL_PAGE_RST;
      pc_r <= `TBL_PC_RST;
    end else begin
      state_r <= state_nxt;
      page_r <= page_nxt;
      pc_r <= pc_nxt;
    end
  end

  // request and command capture
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_r <= '0;
      cmd_r <= '0;
    end else if (accept) begin
      req_r <= req_i;
      cmd_r <= cmd_new;
    end
  end

  // read result capture on the array answer
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= '0;
    end else if (acked && is_read_r) begin
      rdata_r <= rd_fmt;
    end
  end

  // outputs
  assign req_ready_o = (state_r == ST_IDLE);
  assign resp_valid_o = (state_r == ST_DONE);
  assign rdata_o = rdata_r;
  assign page_o = page_r;
  assign pc_o = pc_r;
  assign mem_req_o = (state_r == ST_ACCESS);
  assign mem_cmd_o = cmd_r;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // ack on a read of the given kind
  sequence s_rd_ack(tbl_op_t k, logic bm, logic bs);
    acked && req_r.op == k && req_r.byte_mode == bm && bsel_r == bs;
  endsequence

  // request accepted, then array access pending
  sequence s_accept;
    accept ##1 mem_req_o;
  endsequence

  // word read returns the lower program word unchanged
  a_read_low_word: assert property (
    s_rd_ack(OP_READ_LOW, 1'b0, 1'b0) |=>
      rdata_o == $past(mem_rdata_i[15:0]) && resp_valid_o)
    else $error("read low word mismatch");

  // byte read picks the byte named by the select
  a_read_low_byte: assert property (
    acked && req_r.op == OP_READ_LOW && req_r.byte_mode |=>
      rdata_o == {8'h00, ($past(req_r.ea[0]) ?
        $past(mem_rdata_i[15:8]) : $past(mem_rdata_i[7:0]))})
    else $error("read low byte mismatch");

  // high word read zero-fills the top byte
  a_read_high_word: assert property (
    s_rd_ack(OP_READ_HIGH, 1'b0, 1'b0) |=>
      rdata_o == {8'h00, $past(mem_rdata_i[23:16])})
    else $error("read high word mismatch");

  // selected phantom byte always reads zero
  a_phantom_zero: assert property (
    s_rd_ack(OP_READ_HIGH, 1'b1, 1'b1) |=> rdata_o == 16'h0000)
    else $error("phantom byte not zero");

  // low forms touch only low lanes, high forms only the top lane
  a_lane_split: assert property (
    mem_req_o |-> (cmd_r.wmask[2] == 1'b0 || req_r.op == OP_WRITE_HIGH)
      && (cmd_r.wmask[1:0] == 2'h0 || req_r.op == OP_WRITE_LOW))
    else $error("table op touched wrong space");

  // word address is the page low bits over ea bits 15..1
  a_addr_map: assert property (
    accept |=> mem_cmd_o.addr ==
      {$past(page_r[6:0]), $past(req_i.ea[15:1])})
    else $error("word address mismatch");

  // space select follows page bit 7 as it stood at acceptance
  a_space_sel: assert property (
    s_accept |-> mem_cmd_o.cfg == $past(page_r[7]))
    else $error("space select mismatch");

  // counter steps by two per program word
  a_pc_step: assert property (
    pc_step_i && !pc_load_i |=> pc_o == $past(pc_o) + 24'h000002)
    else $error("counter did not step by two");

  // word write to the low space enables both low lanes
  a_write_word: assert property (
    accept && is_write && !req_i.byte_mode && req_i.op == OP_WRITE_LOW
      |=> mem_cmd_o.we && mem_cmd_o.wmask == 3'h3
        && mem_cmd_o.wdata[15:0] == $past(req_i.wdata))
    else $error("word write mismatch");

  // byte write to the low space enables one lane
  a_byte_select: assert property (
    accept && req_i.op == OP_WRITE_LOW && req_i.byte_mode |=>
      mem_cmd_o.wmask == ($past(req_i.ea[0]) ? 3'h2 : 3'h1))
    else $error("byte select mismatch");

  // load wins and sets the counter directly
  a_pc_load: assert property (
    pc_load_i |=> pc_o == $past(pc_load_val_i))
    else $error("counter load mismatch");

  // page register takes the core's value at the next edge
  a_page_load: assert property (
    page_we_i |=> page_o == $past(page_wdata_i))
    else $error("page load mismatch");

  // byte write copies the source byte onto both low lanes
  a_low_byte_data: assert property (
    accept && req_i.op == OP_WRITE_LOW && req_i.byte_mode |=>
      mem_cmd_o.wdata[15:8] == $past(req_i.wdata[7:0])
        && mem_cmd_o.wdata[7:0] == $past(req_i.wdata[7:0]))
    else $error("byte write data mismatch");

  // high write lands on the top lane; phantom byte writes nothing
  a_high_write: assert property (
    accept && req_i.op == OP_WRITE_HIGH |=> mem_cmd_o.we
      && mem_cmd_o.wmask == ($past(req_i.byte_mode && req_i.ea[0]) ?
        `TBL_MASK_NONE : `TBL_MASK_B2)
      && mem_cmd_o.wdata[23:16] == $past(req_i.wdata[7:0]))
    else $error("high write mismatch");

  // even byte of the high space reads the top program byte
  a_read_high_byte: assert property (
    s_rd_ack(OP_READ_HIGH, 1'b1, 1'b0) |=> rdata_o == {8'h00, $past(mem_rdata_i[23:16])})
    else $error("read high byte mismatch");

  // reads never enable a write lane
  a_read_no_lane: assert property (
    mem_req_o && !mem_cmd_o.we |-> mem_cmd_o.wmask == `TBL_MASK_NONE)
    else $error("read enabled a lane");

  // array command holds while the array is still working
  a_cmd_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_cmd_o))
    else $error("array command moved while pending");

  // a request while busy leaves the command untouched
  a_busy_refuse: assert property (
    req_valid_i && !req_ready_o |=> $stable(mem_cmd_o))
    else $error("request taken while busy");

  // a write answer leaves the last read result in place
  a_write_keeps_rdata: assert property (
    acked && !is_read_r |=> $stable(rdata_o))
    else $error("write disturbed read result");

  // answer lasts one cycle, then the unit is idle again
  a_done_pulse: assert property (
    acked |=> resp_valid_o ##1 !resp_valid_o && req_ready_o)
    else $error("answer not one cycle");

endmodule : program_space_table_access

`default_nettype wire

// ---- program_space_table_access_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_space_table_access_tb;
  import tbl_access_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, ready, resp_valid, page_we = 1'b0;
  logic pc_load = 1'b0, pc_step = 1'b0, mem_req, mem_ack, slow = 1'b0;
  tbl_req_t req = '0; // request to the unit
  mem_cmd_t mem_cmd; // command to the array
  logic [15:0] rdata, rnd = 16'h0032, ea, w, h, b;
  logic [7:0] page_wd = 8'h00, page, pg;
  logic [23:0] pc_val = 24'h000000, pc, mem_rdata;
  logic [16:0] exp_q [$]; // flag bit 16 marks a read result
  int n_mismatch = 0, n_tests = 0;
  always #5 clk = ~clk;
  program_space_table_access dut (.core_clk_i(clk), .resetn_i(rstn), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .resp_valid_o(resp_valid), .rdata_o(rdata),
    .page_we_i(page_we), .page_wdata_i(page_wd), .page_o(page), .pc_load_i(pc_load),
    .pc_load_val_i(pc_val), .pc_step_i(pc_step), .pc_o(pc), .mem_req_o(mem_req),
    .mem_cmd_o(mem_cmd), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
  prog_array_model u_array (.clk_i(clk), .resetn_i(rstn), .req_i(mem_req), .cmd_i(mem_cmd),
    .slow_i(slow), .ack_o(mem_ack), .rdata_o(mem_rdata));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // one table op: hold the request until taken, then check the array command
  task automatic do_op(input tbl_op_t op, input logic bm, input logic [15:0] a,
      input logic [15:0] wd, input logic [16:0] e);
    int n;
    logic [2:0] m;
    n = 0;
    m = !op[1] ? 3'h0 : (op == OP_WRITE_LOW) ? (!bm ? 3'h3 : (a[0] ? 3'h2 : 3'h1))
      : ((bm && a[0]) ? 3'h0 : 3'h4);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, bm, a, wd};
    slow <= rnd[0];
    rnd = lfsr(rnd);
    @(negedge clk);
    while (ready !== 1'b1) begin
      if (++n > 50) begin
        chk("ready_wait", 40'h1, 40'h0);
        close_out();
      end
      @(negedge clk);
    end
    exp_q.push_back(e);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("mem_cmd", {1'b1, op[1], m, pg, a[15:1]}, {mem_req, mem_cmd.we, mem_cmd.wmask,
      mem_cmd.cfg, mem_cmd.addr});
  endtask : do_op
  task automatic set_page(input logic [7:0] p);
    @(posedge clk);
    page_we <= 1'b1;
    page_wd <= p;
    pg = p;
    @(posedge clk);
    page_we <= 1'b0;
    @(negedge clk);
    chk("page", {32'h0, p}, {32'h0, page});
  endtask : set_page
  task automatic pc_drive(input logic ld, input logic st, input logic [23:0] v,
      input logic [23:0] e);
    @(posedge clk);
    pc_load <= ld;
    pc_step <= st;
    pc_val <= v;
    @(posedge clk);
    pc_load <= 1'b0;
    pc_step <= 1'b0;
    @(negedge clk);
    chk("pc", {16'h0, e}, {16'h0, pc});
  endtask : pc_drive
  // result watcher: oldest note against each finished op
  always @(negedge clk) begin : mon
    logic [16:0] e;
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("spare_resp", 40'h0, 40'h1);
      else begin
        e = exp_q.pop_front();
        if (e[16]) chk("rdata", {24'h0, e[15:0]}, {24'h0, rdata});
      end
    end
  end
  initial begin
    @(negedge clk);
    chk("reset", {1'b1, 2'h0, 8'h00, 24'h0}, {ready, resp_valid, mem_req, page, pc});
    @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      set_page({i[0], rnd[6:0]});
      ea = lfsr(rnd) & 16'hfffe;
      w = lfsr(ea);
      h = lfsr(w);
      b = ~w;
      rnd = lfsr(h);
      do_op(OP_WRITE_LOW, 1'b0, ea | 16'h1, w, 17'h0);
      do_op(OP_WRITE_HIGH, 1'b0, ea, h, 17'h0);
      do_op(OP_READ_LOW, 1'b0, ea | 16'h1, 16'h0, {1'b1, w});
      do_op(OP_READ_LOW, 1'b1, ea, 16'h0, {9'h100, w[7:0]});
      do_op(OP_READ_LOW, 1'b1, ea | 16'h1, 16'h0, {9'h100, w[15:8]});
      do_op(OP_READ_HIGH, 1'b0, ea | 16'h1, 16'h0, {9'h100, h[7:0]});
      do_op(OP_READ_HIGH, 1'b1, ea, 16'h0, {9'h100, h[7:0]});
      do_op(OP_READ_HIGH, 1'b1, ea | 16'h1, 16'h0, 17'h10000);
      do_op(OP_WRITE_LOW, 1'b1, ea | 16'h1, b, 17'h0);
      do_op(OP_WRITE_HIGH, 1'b1, ea, w, 17'h0);
      do_op(OP_WRITE_HIGH, 1'b1, ea | 16'h1, b, 17'h0);
      set_page(pg ^ 8'h80);
      do_op(OP_WRITE_LOW, 1'b0, ea, b, 17'h0);
      set_page(pg ^ 8'h80);
      do_op(OP_READ_LOW, 1'b0, ea, 16'h0, {1'b1, b[7:0], w[7:0]});
      do_op(OP_READ_HIGH, 1'b0, ea, 16'h0, {9'h100, w[7:0]});
    end
    pc_drive(1'b1, 1'b0, 24'hfffffe, 24'hfffffe);
    pc_drive(1'b0, 1'b1, 24'h000000, 24'h000000);
    pc_drive(1'b0, 1'b1, 24'h000000, 24'h000002);
    pc_drive(1'b1, 1'b1, {rnd, 8'h10}, {rnd, 8'h10});
    repeat (5) @(negedge clk);
    chk("pending", 40'h0, {8'h0, exp_q.size()});
    close_out();
  end
endmodule : program_space_table_access_tb
`default_nettype wire

// ---- tbl_access_map.svh ----
`ifndef TBL_ACCESS_MAP_SVH
`define TBL_ACCESS_MAP_SVH

// table page register width and layout
`define TBL_PAGE_W 8
`define TBL_PAGE_RST 8'h00
`define TBL_CFG_BIT 7
`define TBL_PAGE_MSB 6

// data word and program word widths
`define TBL_DATA_W 16
`define TBL_PWORD_W 24
`define TBL_EA_W 16
`define TBL_WADDR_W 22

// byte positions inside a program word
`define TBL_B0_LSB 0
`define TBL_B1_LSB 8
`define TBL_B2_LSB 16

// byte lane masks toward the array
`define TBL_MASK_NONE 3'h0
`define TBL_MASK_B0 3'h1
`define TBL_MASK_B1 3'h2
`define TBL_MASK_LOW 3'h3
`define TBL_MASK_B2 3'h4

// program counter
`define TBL_PC_W 24
`define TBL_PC_RST 24'h000000
`define TBL_PC_STEP 24'h000002

`endif

// ---- tbl_access_pkg.sv ----
`include "tbl_access_map.svh"

package tbl_access_pkg;

  // table instruction kinds
  typedef enum logic [1:0] {
    OP_READ_LOW = 2'h0,
    OP_READ_HIGH = 2'h1,
    OP_WRITE_LOW = 2'h2,
    OP_WRITE_HIGH = 2'h3
  } tbl_op_t;

  // one table request from the core
  typedef struct packed {
    tbl_op_t op;
    logic byte_mode;
    logic [`TBL_EA_W-1:0] ea;
    logic [`TBL_DATA_W-1:0] wdata;
  } tbl_req_t;

  // one access toward the program array
  typedef struct packed {
    logic we;
    logic cfg;
    logic [`TBL_WADDR_W-1:0] addr;
    logic [`TBL_PWORD_W-1:0] wdata;
    logic [2:0] wmask;
  } mem_cmd_t;

endpackage : tbl_access_pkg

// ---- tbl_read_format.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbl_access_map.svh"

module tbl_read_format (
  input wire tbl_access_pkg::tbl_op_t op_i, // table operation
  input wire logic byte_mode_i, // byte transfer
  input wire logic bsel_i, // byte select
  input wire logic [`TBL_PWORD_W-1:0] pword_i, // program word
  output logic [`TBL_DATA_W-1:0] data_o // destination word
);
  import tbl_access_pkg::*;

  // byte lanes of the program word
  wire [7:0] lane0 = pword_i[`TBL_B0_LSB +: 8];
  wire [7:0] lane1 = pword_i[`TBL_B1_LSB +: 8];
  wire [7:0] lane2 = pword_i[`TBL_B2_LSB +: 8];
  wire is_high = (op_i == OP_READ_HIGH);

  // low space: whole word or one selected byte
  wire [`TBL_DATA_W-1:0] low_word = {lane1, lane0};
  wire [7:0] low_byte = bsel_i ? lane1 : lane0;
  // high space: phantom byte always reads zero
  wire [7:0] high_byte = bsel_i ? 8'h00 : lane2;

  // word mode ignores the byte select
  wire [`TBL_DATA_W-1:0] low_res =
    byte_mode_i ? {8'h00, low_byte} : low_word;
  wire [`TBL_DATA_W-1:0] high_res =
    byte_mode_i ? {8'h00, high_byte} : {8'h00, lane2};

  assign data_o = is_high ? high_res : low_res;

endmodule : tbl_read_format

`default_nettype wire

// ---- tbl_write_lane.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tbl_access_map.svh"

module tbl_write_lane (
  input wire tbl_access_pkg::tbl_op_t op_i, // table operation
  input wire logic byte_mode_i, // byte transfer
  input wire logic bsel_i, // byte select
  input wire logic [`TBL_DATA_W-1:0] wdata_i, // source data
  output logic [`TBL_PWORD_W-1:0] pdata_o, // data on lanes
  output logic [2:0] mask_o // lane enables
);
  import tbl_access_pkg::*;

  wire [7:0] src_lo = wdata_i[7:0];
  wire is_high = (op_i == OP_WRITE_HIGH);

  // source byte lands on the lane it addresses
  wire [7:0] lane1 = byte_mode_i ? src_lo : wdata_i[15:8];
  assign pdata_o = {src_lo, lane1, src_lo};

  // low space lanes
  wire [2:0] low_byte_m = bsel_i ? `TBL_MASK_B1 : `TBL_MASK_B0;
  wire [2:0] low_m = byte_mode_i ? low_byte_m : `TBL_MASK_LOW;
  // high space: phantom byte writes nothing
  wire [2:0] high_m = (byte_mode_i && bsel_i) ? `TBL_MASK_NONE : `TBL_MASK_B2;

  assign mask_o = is_high ? high_m : low_m;

endmodule : tbl_write_lane

`default_nettype wire
